/* File: common/irq_flag_pkg.sv */
// Constants and types shared by the peripheral interrupt flag bank
package irq_flag_pkg;

    // Bus and register widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 8;
    localparam int STAT_W = 4;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_FLAGS_3 = 10'h08F;
    localparam logic [9:0] IDX_FLAGS_4 = 10'h090;
    localparam logic [9:0] IDX_FLAGS_5 = 10'h091;
    localparam logic [9:0] IDX_FLAGS_6 = 10'h092;
    localparam logic [9:0] IDX_STATUS  = 10'h0A0;
    localparam logic [9:0] IDX_MASK    = 10'h0A1;

    // Reset values
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [STAT_W-1:0] STAT_RESET  = 4'h0;

    // Software-writable bits of each flag register
    localparam logic [FLAG_W-1:0] WR_MASK_3 = 8'h0F;
    localparam logic [FLAG_W-1:0] WR_MASK_4 = 8'h3F;
    localparam logic [FLAG_W-1:0] WR_MASK_5 = 8'hFC;
    localparam logic [FLAG_W-1:0] WR_MASK_6 = 8'h07;

    // Flag register 3 positions
    localparam int POS_MOD2_PARAM  = 3;
    localparam int POS_MOD2_PERIOD = 2;
    localparam int POS_MOD1_PARAM  = 1;
    localparam int POS_MOD1_PERIOD = 0;
    // Flag register 4 positions
    localparam int POS_SERIAL1_RX  = 7;
    localparam int POS_SERIAL1_TX  = 6;
    localparam int POS_CELL4       = 5;
    localparam int POS_CELL3       = 4;
    localparam int POS_CELL2       = 3;
    localparam int POS_CELL1       = 2;
    localparam int POS_WAVEFORM    = 1;
    localparam int POS_OSC         = 0;
    // Flag register 5 positions
    localparam int POS_COMP2       = 7;
    localparam int POS_COMP1       = 6;
    localparam int POS_SYNC2_COLL  = 5;
    localparam int POS_SYNC2_EVT   = 4;
    localparam int POS_SYNC1_COLL  = 3;
    localparam int POS_SYNC1_EVT   = 2;
    localparam int POS_SERIAL2_RX  = 1;
    localparam int POS_SERIAL2_TX  = 0;
    // Flag register 6 positions
    localparam int POS_ZERO_CROSS  = 2;
    localparam int POS_CONV_THRESH = 1;
    localparam int POS_CONV_DONE   = 0;

    // One-cycle event pulses from the peripherals
    typedef struct packed {
        logic mod2_param;
        logic mod2_period;
        logic mod1_param;
        logic mod1_period;
        logic logic_cell4;
        logic logic_cell3;
        logic logic_cell2;
        logic logic_cell1;
        logic waveform_gen;
        logic osc_unit;
        logic comparator2;
        logic comparator1;
        logic sync2_collision;
        logic sync2_event;
        logic sync1_collision;
        logic sync1_event;
        logic zero_cross;
        logic conv_threshold;
        logic conv_done;
    } periph_event_t;

    // Buffer state levels from the two serial ports
    typedef struct packed {
        logic serial1_rx_pending;
        logic serial1_tx_empty;
        logic serial2_rx_pending;
        logic serial2_tx_empty;
    } buffer_state_t;

endpackage

/* File: logic/sticky_flag_reg.sv */
// One register of sticky flags: hardware sets, software writes
`timescale 1ns/100ps
module sticky_flag_reg #(
    parameter int                WIDTH   = 8,
    parameter logic [WIDTH-1:0]  WR_MASK = '1
) (
    // Clock and control
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Hardware set and software write
    input  wire logic [WIDTH-1:0] set,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    // Flag state
    output logic      [WIDTH-1:0] flags
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("sticky_flag_reg: WIDTH must be at least 1");
        end
    endgenerate

    // Set wins over a clearing write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= '0;
        end else if (ce) begin
            flags <= (set & WR_MASK) | ((wr_en ? wr_data : flags) & WR_MASK);
        end
    end
endmodule // sticky_flag_reg

/* File: logic/irq_status_unit.sv */
// Sticky interrupt status, read-to-clear, with mask and level output
`timescale 1ns/100ps
module irq_status_unit #(
    parameter int WIDTH = 4
) (
    // Clock and control
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Events and software access
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic             rd_clear,
    input  wire logic             mask_wr,
    input  wire logic [WIDTH-1:0] mask_data,
    // State
    output logic      [WIDTH-1:0] status,
    output logic      [WIDTH-1:0] mask,
    output logic                  irq
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("irq_status_unit: WIDTH must be at least 1");
        end
    endgenerate

    // An event in the clearing read's cycle survives it
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
        end else if (ce) begin
            status <= event_in | (rd_clear ? '0 : status);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= '0;
        end else if (ce && mask_wr) begin
            mask <= mask_data;
        end
    end

    // Registered so the top output comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(event_in & mask) | (|(status & mask) & ~rd_clear)
                   | (|(event_in & mask_data) & mask_wr);
        end
    end
endmodule // irq_status_unit

/* File: logic/periph_irq_flag_bank.sv */
// Peripheral interrupt request flag bank with APB register access
`timescale 1ns/100ps
module periph_irq_flag_bank
    import irq_flag_pkg::*;
(
    // Clock, reset, clock enable
    input  wire logic                       CLK,
    input  wire logic                       SYS_RST,
    input  wire logic                       CE,
    // APB slave
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [irq_flag_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [irq_flag_pkg::DATA_W-1:0] PWDATA,
    output logic      [irq_flag_pkg::DATA_W-1:0] PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    // Peripheral events and serial buffer state
    input  wire irq_flag_pkg::periph_event_t EVENTS,
    input  wire irq_flag_pkg::buffer_state_t BUFFERS,
    // Interrupt
    output logic                            IRQ
);
    import irq_flag_pkg::*;

    logic [FLAG_W-1:0] flags_3;
    logic [FLAG_W-1:0] flags_4;
    logic [FLAG_W-1:0] flags_5;
    logic [FLAG_W-1:0] flags_6;
    logic [FLAG_W-1:0] set_3;
    logic [FLAG_W-1:0] set_4;
    logic [FLAG_W-1:0] set_5;
    logic [FLAG_W-1:0] set_6;
    logic [FLAG_W-1:0] reg_4;
    logic [FLAG_W-1:0] reg_5;
    buffer_state_t     buf_state;
    buffer_state_t     buf_prev;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [STAT_W-1:0] stat_event;
    logic              irq_level;
    logic [9:0]        index;
    logic              aligned;
    logic              access;
    logic              commit;
    logic              wr_commit;
    logic              hit;
    logic [FLAG_W-1:0] next_rdata;
    logic              wr_3;
    logic              wr_4;
    logic              wr_5;
    logic              wr_6;
    logic              wr_mask;
    logic              rd_status;

    // Same-clock peripheral events: no synchroniser needed
    // sets take effect only while CE is high, as the flag registers gate them with ce
    always_comb begin
        set_3 = '0;
        set_4 = '0;
        set_5 = '0;
        set_6 = '0;
        set_3[POS_MOD2_PARAM]  = EVENTS.mod2_param;
        set_3[POS_MOD1_PARAM]  = EVENTS.mod1_param;
        set_3[POS_MOD2_PERIOD] = EVENTS.mod2_period;
        set_3[POS_MOD1_PERIOD] = EVENTS.mod1_period;
        set_4[POS_CELL4]       = EVENTS.logic_cell4;
        set_4[POS_CELL3]       = EVENTS.logic_cell3;
        set_4[POS_CELL2]       = EVENTS.logic_cell2;
        set_4[POS_CELL1]       = EVENTS.logic_cell1;
        set_4[POS_WAVEFORM]    = EVENTS.waveform_gen;
        set_4[POS_OSC]         = EVENTS.osc_unit;
        set_5[POS_COMP2]       = EVENTS.comparator2;
        set_5[POS_COMP1]       = EVENTS.comparator1;
        set_5[POS_SYNC2_COLL]  = EVENTS.sync2_collision;
        set_5[POS_SYNC1_COLL]  = EVENTS.sync1_collision;
        set_5[POS_SYNC2_EVT]   = EVENTS.sync2_event;
        set_5[POS_SYNC1_EVT]   = EVENTS.sync1_event;
        set_6[POS_ZERO_CROSS]  = EVENTS.zero_cross;
        set_6[POS_CONV_THRESH] = EVENTS.conv_threshold;
        set_6[POS_CONV_DONE]   = EVENTS.conv_done;
    end

    // APB decode; the slave answers on the second access cycle
    assign index     = PADDR[ADDR_W-1:2];
    assign aligned   = (PADDR[1:0] == 2'b00);
    assign access    = PSEL && PENABLE;
    assign commit    = access && PREADY;
    assign wr_commit = commit && PWRITE && !PSLVERR;
    assign hit       = aligned && (index == IDX_FLAGS_3 || index == IDX_FLAGS_4 || index == IDX_FLAGS_5
                       || index == IDX_FLAGS_6 || index == IDX_STATUS || index == IDX_MASK);

    assign wr_3      = wr_commit && (index == IDX_FLAGS_3);
    assign wr_4      = wr_commit && (index == IDX_FLAGS_4);
    assign wr_5      = wr_commit && (index == IDX_FLAGS_5);
    assign wr_6      = wr_commit && (index == IDX_FLAGS_6);
    assign wr_mask   = wr_commit && (index == IDX_MASK);
    // Status clears where its read data is captured, so an event that
    // arrives in the ready cycle is latched afresh instead of being lost
    assign rd_status = access && !PREADY && !PWRITE && hit && (index == IDX_STATUS);

    sticky_flag_reg #(.WIDTH(FLAG_W), .WR_MASK(WR_MASK_3)) u_flags_3 (
        .clk     (CLK),
        .rst     (SYS_RST),
        .ce      (CE),
        .set     (set_3),
        .wr_en   (wr_3),
        .wr_data (PWDATA[FLAG_W-1:0]),
        .flags   (flags_3)
    );

    sticky_flag_reg #(.WIDTH(FLAG_W), .WR_MASK(WR_MASK_4)) u_flags_4 (
        .clk     (CLK),
        .rst     (SYS_RST),
        .ce      (CE),
        .set     (set_4),
        .wr_en   (wr_4),
        .wr_data (PWDATA[FLAG_W-1:0]),
        .flags   (flags_4)
    );

    sticky_flag_reg #(.WIDTH(FLAG_W), .WR_MASK(WR_MASK_5)) u_flags_5 (
        .clk     (CLK),
        .rst     (SYS_RST),
        .ce      (CE),
        .set     (set_5),
        .wr_en   (wr_5),
        .wr_data (PWDATA[FLAG_W-1:0]),
        .flags   (flags_5)
    );

    sticky_flag_reg #(.WIDTH(FLAG_W), .WR_MASK(WR_MASK_6)) u_flags_6 (
        .clk     (CLK),
        .rst     (SYS_RST),
        .ce      (CE),
        .set     (set_6),
        .wr_en   (wr_6),
        .wr_data (PWDATA[FLAG_W-1:0]),
        .flags   (flags_6)
    );

    // buffer flags follow the serial ports' state
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            buf_state <= '0;
            buf_prev  <= '0;
        end else if (CE) begin
            buf_state <= BUFFERS;
            buf_prev  <= buf_state;
        end
    end

    // read-only bits come from buffer state, never from a write
    always_comb begin
        reg_4                 = flags_4;
        reg_4[POS_SERIAL1_RX] = buf_state.serial1_rx_pending;
        reg_4[POS_SERIAL1_TX] = buf_state.serial1_tx_empty;
        reg_5                 = flags_5;
        reg_5[POS_SERIAL2_RX] = buf_state.serial2_rx_pending;
        reg_5[POS_SERIAL2_TX] = buf_state.serial2_tx_empty;
    end

    // One status bit per flag register: a new set or a buffer flag rising
    always_comb begin
        stat_event    = '0;
        stat_event[0] = |(set_3 & WR_MASK_3);
        stat_event[1] = |(set_4 & WR_MASK_4) | (buf_state.serial1_rx_pending & ~buf_prev.serial1_rx_pending)
                        | (buf_state.serial1_tx_empty & ~buf_prev.serial1_tx_empty);
        stat_event[2] = |(set_5 & WR_MASK_5) | (buf_state.serial2_rx_pending & ~buf_prev.serial2_rx_pending)
                        | (buf_state.serial2_tx_empty & ~buf_prev.serial2_tx_empty);
        stat_event[3] = |(set_6 & WR_MASK_6);
    end

    irq_status_unit #(.WIDTH(STAT_W)) u_status (
        .clk       (CLK),
        .rst       (SYS_RST),
        .ce        (CE),
        .event_in  (stat_event),
        .rd_clear  (rd_status),
        .mask_wr   (wr_mask),
        .mask_data (PWDATA[STAT_W-1:0]),
        .status    (status),
        .mask      (mask),
        .irq       (irq_level)
    );

    assign IRQ = irq_level;

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        if (aligned) begin
            unique case (index)
                IDX_FLAGS_3: next_rdata = flags_3;
                IDX_FLAGS_4: next_rdata = reg_4;
                IDX_FLAGS_5: next_rdata = reg_5;
                IDX_FLAGS_6: next_rdata = flags_6;
                IDX_STATUS:  next_rdata = {{(FLAG_W-STAT_W){1'b0}}, status};
                IDX_MASK:    next_rdata = {{(FLAG_W-STAT_W){1'b0}}, mask};
                default:     next_rdata = '0;
            endcase
        end
    end

    // One wait state keeps read data and error in flops
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
        end else if (CE) begin
            PREADY  <= access && !PREADY;
            PSLVERR <= access && !PREADY && !hit;
            if (access && !PREADY && !PWRITE) begin
                PRDATA <= {{(DATA_W-FLAG_W){1'b0}}, next_rdata};
            end else if (commit) begin
                PRDATA <= '0;
            end
        end
    end
endmodule // periph_irq_flag_bank

/* File: test/periph_irq_flag_bank_props.sv */
// Concurrent checks on the ports of the peripheral interrupt flag bank
`timescale 1ns/100ps
module periph_irq_flag_bank_props (
    // Clock and reset
    input wire logic                              CLK,
    input wire logic                              SYS_RST,
    // APB slave
    input wire logic                              PSEL,
    input wire logic                              PENABLE,
    input wire logic                              PWRITE,
    input wire logic [irq_flag_pkg::ADDR_W-1:0]   PADDR,
    input wire logic [irq_flag_pkg::DATA_W-1:0]   PRDATA,
    input wire logic                              PREADY,
    input wire logic                              PSLVERR,
    // Interrupt
    input wire logic                              IRQ
);
    import irq_flag_pkg::*;

    logic mapped;
    assign mapped = PADDR[1:0] == 2'h0 && PADDR[11:2] inside
                    {IDX_FLAGS_3, IDX_FLAGS_4, IDX_FLAGS_5, IDX_FLAGS_6, IDX_STATUS, IDX_MASK};

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    setup_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == '0)
        else $error("read data outside ready cycle");
    rdata_top_a: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    slverr_ready_a: assert property (PSLVERR |-> PREADY && PRDATA == '0)
        else $error("error without ready or with data");
    slverr_map_a: assert property (PREADY |-> PSLVERR == !mapped)
        else $error("error response does not match address map");
    rst_quiet_a: assert property ($past(SYS_RST) |-> !IRQ && !PREADY && !PSLVERR)
        else $error("outputs active after reset");
    flags6_top_a: assert property (PREADY && !PWRITE && PADDR == {IDX_FLAGS_6, 2'h0} |-> PRDATA[7:3] == 5'h00)
        else $error("unimplemented bits read nonzero");
    flags3_top_a: assert property (PREADY && !PWRITE && PADDR == {IDX_FLAGS_3, 2'h0} |-> PRDATA[7:4] == 4'h0)
        else $error("upper flag bits read nonzero");
endmodule // periph_irq_flag_bank_props

bind periph_irq_flag_bank periph_irq_flag_bank_props u_props (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ));

/* File: test/periph_model.sv */
// Peripheral side model: event pulses and serial buffer levels
`timescale 1ns/100ps
module periph_model (
    // Clock
    input  wire logic                   clk,
    // Towards the flag bank
    output irq_flag_pkg::periph_event_t events,
    output irq_flag_pkg::buffer_state_t buffers
);
    import irq_flag_pkg::*;

    initial begin
        events = '0;
        buffers = '0;
    end

    // single-cycle events
    // Same clock as the bank, so no synchroniser is modelled
    task automatic pulse(input int idx);
        events[idx] <= 1'b1;
        @(posedge clk);
        events[idx] <= 1'b0;
    endtask

    task automatic set_buffers(input buffer_state_t b);
        buffers <= b;
    endtask
endmodule // periph_model

/* File: test/test_periph_irq_flag_bank.sv */
// Self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/100ps
module test_periph_irq_flag_bank;
    import irq_flag_pkg::*;

    localparam logic [11:0] A3 = {IDX_FLAGS_3, 2'h0};
    localparam logic [11:0] A4 = {IDX_FLAGS_4, 2'h0};
    localparam logic [11:0] A5 = {IDX_FLAGS_5, 2'h0};
    localparam logic [11:0] A6 = {IDX_FLAGS_6, 2'h0};
    localparam logic [11:0] AS = {IDX_STATUS, 2'h0};
    localparam logic [11:0] AM = {IDX_MASK, 2'h0};

    logic          clk = 1'b0;
    logic          sys_rst = 1'b1;
    logic          ce = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [11:0]   paddr = '0;
    logic [31:0]   pwdata = '0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    periph_event_t events;
    buffer_state_t buffers;
    int            mismatches = 0;
    int            n_tests = 0;

    periph_irq_flag_bank dut (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EVENTS(events), .BUFFERS(buffers), .IRQ(irq));
    periph_model peri (.clk(clk), .events(events), .buffers(buffers));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until ready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, a, d, rd, err);
        check_bit(err, e);
    endtask

    task automatic rd_expect(input logic [11:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] rd;
        logic        err;
        xfer(1'b0, a, 32'h0, rd, err);
        check_data(rd, exp);
        check_bit(err, e);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole sequence needs well under 2000 cycles
    initial begin
        #(4 * 20000);
        mismatches++;
        print_verdict();
    end

    initial begin
        logic [11:0] a;
        logic [11:0] regs [6];
        logic [7:0]  wmask [4];
        logic [31:0] rd;
        logic        err;
        int          b;
        regs = '{A3, A4, A5, A6, AS, AM};
        wmask = '{8'h0F, 8'h3F, 8'hFC, 8'h07};
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 6; k++) rd_expect(regs[k], 32'h0, 1'b0);
        // Unmapped and unaligned places answer with an error and ignore writes
        rd_expect(12'h300, 32'h0, 1'b1);
        wr(12'h249, 32'hFF, 1'b1);
        rd_expect(A6, 32'h0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wr(regs[k], 32'hFF, 1'b0);
            rd_expect(regs[k], {24'h0, wmask[k]}, 1'b0);
            wr(regs[k], 32'h0, 1'b0);
        end
        // Every event with the mask at zero
        for (int i = 0; i < 19; i++) begin
            if (i >= 15) begin a = A3; b = i - 15; end
            else if (i >= 9) begin a = A4; b = i - 9; end
            else if (i >= 3) begin a = A5; b = i - 1; end
            else begin a = A6; b = i; end
            peri.pulse(i);
            @(posedge clk);
            rd_expect(a, 32'h1 << b, 1'b0);
            rd_expect(a, 32'h1 << b, 1'b0);
            check_bit(irq, 1'b0);
            wr(a, 32'h0, 1'b0);
            rd_expect(a, 32'h0, 1'b0);
        end
        // Buffer flags follow levels and ignore writes
        peri.set_buffers(4'b1010);
        rd_expect(A4, 32'h80, 1'b0);
        rd_expect(A5, 32'h02, 1'b0);
        wr(A4, 32'hFF, 1'b0);
        rd_expect(A4, 32'hBF, 1'b0);
        wr(A4, 32'h00, 1'b0);
        rd_expect(A4, 32'h80, 1'b0);
        peri.set_buffers(4'b0101);
        rd_expect(A4, 32'h40, 1'b0);
        rd_expect(A5, 32'h01, 1'b0);
        peri.set_buffers(4'b0000);
        // Hardware set in the completing cycle of a clearing write
        fork
            wr(A6, 32'h0, 1'b0);
            begin
                repeat (3) @(posedge clk);
                peri.pulse(0);
            end
        join
        rd_expect(A6, 32'h1, 1'b0);
        wr(A6, 32'h0, 1'b0);
        // Interrupt raised, masked in, cleared by status read
        xfer(1'b0, AS, 32'h0, rd, err);
        wr(AM, 32'h8, 1'b0);
        rd_expect(AM, 32'h8, 1'b0);
        peri.pulse(2);
        @(posedge clk);
        #1 check_bit(irq, 1'b1);
        wr(A6, 32'h0, 1'b0);
        rd_expect(AS, 32'h8, 1'b0);
        repeat (2) @(posedge clk);
        #1 check_bit(irq, 1'b0);
        rd_expect(AS, 32'h0, 1'b0);
        // Clock enable low freezes the flags, status and interrupt
        ce <= 1'b0;
        peri.pulse(1);
        ce <= 1'b1;
        rd_expect(A6, 32'h0, 1'b0);
        rd_expect(AS, 32'h0, 1'b0);
        check_bit(irq, 1'b0);
        // Reset in mid-run clears a sticky flag
        peri.pulse(18);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd_expect(A3, 32'h0, 1'b0);
        print_verdict();
    end
endmodule // test_periph_irq_flag_bank
